// ===== logic/ssg_pkg.sv
// ssg_pkg: constants, register map and carrier types of the spindle speed block
// assumes a single 40 MHz clock domain and an AXI4-Lite register port
package ssg_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GMAX0 = 8'h04;
  localparam logic [7:0] ADDR_GMAX3 = 8'h10;
  localparam logic [7:0] ADDR_CMD = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_PLCIN = 8'h1c;
  localparam logic [7:0] ADDR_ALARM = 8'h20;
  // control register field positions
  localparam int unsigned CTRL_ANALOG = 0;
  localparam int unsigned CTRL_FOUR = 1;
  localparam int unsigned CTRL_TTYPE = 2;
  localparam int unsigned CTRL_THREAD = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // widths and scaling
  localparam int unsigned SPEED_W = 17;
  localparam int unsigned DAC_W = 12;
  localparam int unsigned NUM_GEARS = 4;
  localparam logic [11:0] DAC_FULL = 12'hfff;
  localparam logic [16:0] MAX_CODE = 17'h00007;
  localparam logic [16:0] GEAR_MAX_RST = 17'h00bb8;
  localparam logic [6:0] OVR_BASE = 7'h32;
  localparam logic [6:0] OVR_STEP = 7'h0a;
  localparam logic [6:0] PCT_FULL = 7'h64;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // inputs driven by the machine-side ladder program
  typedef struct packed {
    logic [7:0] override_code;
    logic [3:0] gear_in;
    logic aux_done_input;
    logic aux_function_lock;
  } ssg_plc_in_s;

  // outputs toward the ladder program and spindle drive
  typedef struct packed {
    logic speed_strobe;
    logic [31:0] speed_code;
    logic [3:0] gear_report;
    logic [11:0] analog_code;
    logic alarm;
  } ssg_plc_out_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SCALE, ST_PICK, ST_CONV, ST_HANDSHAKE
  } ssg_state_e;
endpackage

// ===== logic/ssg_divider.sv
// ssg_divider: 32-bit restoring divider, one quotient bit per clock
// assumes start is a single-cycle pulse given only while idle
`timescale 1ns/1ps
`default_nettype none
module ssg_divider (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // request
  input wire logic start,
  input wire logic [31:0] dividend,
  input wire logic [31:0] divisor,
  // answer
  output logic done_reg,
  output logic [31:0] quotient_reg
);
  logic [31:0] rem_reg; // partial remainder
  logic [5:0] cnt_reg; // bits left
  logic run_reg; // division in progress
  logic [32:0] trial; // remainder minus divisor

  // trial subtraction; a zero divisor yields all ones, which saturates later
  assign trial = {rem_reg, quotient_reg[31]} - {1'b0, divisor};

  // shift and subtract loop
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rem_reg <= 32'h0;
      quotient_reg <= 32'h0;
      cnt_reg <= 6'h0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start) begin
        quotient_reg <= dividend;
        rem_reg <= 32'h0;
        cnt_reg <= 6'h20;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (!trial[32]) begin
          rem_reg <= trial[31:0];
          quotient_reg <= {quotient_reg[30:0], 1'b1};
        end else begin
          rem_reg <= {rem_reg[30:0], quotient_reg[31]};
          quotient_reg <= {quotient_reg[30:0], 1'b0};
        end
        cnt_reg <= cnt_reg - 6'h1;
        if (cnt_reg == 6'h1) begin
          run_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/ssg_spindle_speed.sv
// ssg_spindle_speed: spindle speed code, gear select and analog speed output
// assumes an AXI4-Lite master with one write and one read in flight at most,
// and ladder program inputs synchronous to clk_sys
//
// Summary of operation
// - control bit selects gear or analog spindle
// - gear mode accepts codes 0..7, else alarm
// - each gear code drives its own output bit
// - strobe announces speed function with gear outputs
// - analog speed equals command times override
// - override code gives 50..120% in 10% steps
// - thread cutting bypasses the override
// - M-type picks gear from per-gear ranges
// - two or four gears are configurable for M-type
// - gear change also pulses the speed strobe
// - per-gear full-scale speed, code spans 0..10V
// - control bit switches to ladder-chosen gear
// - T-type voltage is command over gear maximum
// - gear report out, current gear inputs in
// - speed bit and strobe high awaiting completion
// - no block advance before completion seen high, except under function lock
// - function lock keeps analog output, drops strobe
`timescale 1ns/1ps
`default_nettype none
module ssg_spindle_speed
  import ssg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // ladder program side
  input wire ssg_pkg::ssg_plc_in_s plc_in,
  output ssg_pkg::ssg_plc_out_s plc_out_reg,
  // block sequencing
  output logic busy_reg
);
  import ssg_pkg::*;

  // configuration and command state
  logic [3:0] ctrl_reg; // mode bits
  logic [SPEED_W-1:0] gear_max_reg [NUM_GEARS]; // full-scale speed per gear
  logic [SPEED_W-1:0] cmd_reg; // last commanded speed or code
  logic [SPEED_W-1:0] eff_reg; // speed after override
  logic [1:0] gear_idx_reg; // gear in use
  ssg_state_e state_reg;
  // bus side state
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg; // byte lanes held with the data, the master may move them after the handshake
  logic aw_got_reg;
  logic w_got_reg;
  logic wr_do; // write commits this cycle
  logic cmd_go; // accepted command write
  logic alarm_clr; // software clears alarm
  logic addr_ok_w; // write address is mapped
  // arithmetic
  logic [6:0] pct; // override percentage
  logic div_start_reg;
  logic [31:0] div_num_reg;
  logic [31:0] div_den_reg;
  logic div_done;
  logic [31:0] div_q;
  logic [NUM_GEARS-1:0] fit; // gear covers the effective speed
  logic [1:0] top_idx; // highest configured gear
  logic [1:0] pick_idx; // gear to use
  logic [31:0] rd_mux;
  logic rd_ok;

  ssg_divider u_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(div_start_reg),
    .dividend(div_num_reg),
    .divisor(div_den_reg),
    .done_reg(div_done),
    .quotient_reg(div_q)
  );

  // codes 0..7 map to 50..120 percent
  assign pct = OVR_BASE + 7'(OVR_STEP * {4'h0, plc_in.override_code[2:0]});
  // only two gears for M-type choice when the four-gear bit is clear
  assign top_idx = ctrl_reg[CTRL_FOUR] ? 2'h3 : 2'h1;

  // per-gear range check for automatic selection
  for (genvar g = 0; g < NUM_GEARS; g++) begin : g_fit
    assign fit[g] = gear_max_reg[g] >= eff_reg;
  end

  // gear choice: ladder inputs in T-type, lowest covering gear otherwise
  always_comb begin
    pick_idx = top_idx;
    if (ctrl_reg[CTRL_TTYPE]) begin
      pick_idx = 2'h0;
      for (int i = NUM_GEARS - 1; i >= 0; i--) begin
        if (plc_in.gear_in[i]) begin
          pick_idx = 2'(i);
        end
      end
    end else begin
      for (int i = NUM_GEARS - 1; i >= 0; i--) begin
        if (fit[i] && (2'(i) <= top_idx)) begin
          pick_idx = 2'(i);
        end
      end
    end
  end

  // write decode
  assign wr_do = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign addr_ok_w = (awaddr_reg <= ADDR_ALARM) && (awaddr_reg[1:0] == 2'h0)
    && (awaddr_reg != ADDR_STATUS) && (awaddr_reg != ADDR_PLCIN);
  // a command written while busy is dropped; busy is visible in status
  assign cmd_go = wr_do && (awaddr_reg == ADDR_CMD) && wstrb_reg[0] && (state_reg == ST_IDLE);
  assign alarm_clr = wr_do && (awaddr_reg == ADDR_ALARM) && wstrb_reg[0] && wdata_reg[0];

  // write channels: address and data are taken in either order
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
        aw_got_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_got_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok_w ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // configuration registers; only the low byte lanes are meaningful
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_reg <= CTRL_RST;
      for (int i = 0; i < NUM_GEARS; i++) begin
        gear_max_reg[i] <= GEAR_MAX_RST;
      end
    end else if (wr_do) begin
      if (awaddr_reg == ADDR_CTRL && wstrb_reg[0]) begin
        ctrl_reg <= wdata_reg[3:0];
      end
      for (int i = 0; i < NUM_GEARS; i++) begin
        if (awaddr_reg == ADDR_GMAX0 + 8'(4 * i)) begin
          if (wstrb_reg[0]) gear_max_reg[i][7:0] <= wdata_reg[7:0];
          if (wstrb_reg[1]) gear_max_reg[i][15:8] <= wdata_reg[15:8];
          if (wstrb_reg[2]) gear_max_reg[i][16] <= wdata_reg[16];
        end
      end
    end
  end

  // read mux; status and ladder inputs reflect live state
  always_comb begin
    rd_mux = 32'h0;
    rd_ok = 1'b1;
    if (s_axi_araddr == ADDR_CTRL) begin
      rd_mux = {28'h0, ctrl_reg};
    end else if (s_axi_araddr >= ADDR_GMAX0 && s_axi_araddr <= ADDR_GMAX3 && s_axi_araddr[1:0] == 2'h0) begin
      rd_mux = {15'h0, gear_max_reg[2'(s_axi_araddr[7:2] - 6'h1)]};
    end else if (s_axi_araddr == ADDR_CMD) begin
      rd_mux = {15'h0, cmd_reg};
    end else if (s_axi_araddr == ADDR_STATUS) begin
      rd_mux = {12'h0, plc_out_reg.analog_code, plc_out_reg.gear_report,
        1'b0, plc_out_reg.speed_strobe, plc_out_reg.alarm, busy_reg};
    end else if (s_axi_araddr == ADDR_PLCIN) begin
      rd_mux = {18'h0, plc_in.aux_function_lock, plc_in.aux_done_input,
        plc_in.gear_in, plc_in.override_code};
    end else if (s_axi_araddr == ADDR_ALARM) begin
      rd_mux = {31'h0, plc_out_reg.alarm};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // speed function sequencer
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      cmd_reg <= 17'h0;
      eff_reg <= 17'h0;
      gear_idx_reg <= 2'h0;
      div_start_reg <= 1'b0;
      div_num_reg <= 32'h0;
      div_den_reg <= 32'h0;
      plc_out_reg <= '0;
    end else begin
      div_start_reg <= 1'b0;
      // a fresh out-of-range code wins over a clear in the same cycle
      if (alarm_clr) plc_out_reg.alarm <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (cmd_go) begin
            cmd_reg <= wdata_reg[16:0];
            if (!ctrl_reg[CTRL_ANALOG]) begin
              if (wdata_reg[16:0] > MAX_CODE) begin
                plc_out_reg.alarm <= 1'b1;
              end else if (!plc_in.aux_function_lock) begin
                plc_out_reg.speed_code <= 32'h1 << wdata_reg[2:0];
                plc_out_reg.speed_strobe <= 1'b1;
                busy_reg <= 1'b1;
                state_reg <= ST_HANDSHAKE;
              end
            end else if (ctrl_reg[CTRL_THREAD]) begin
              eff_reg <= wdata_reg[16:0];
              busy_reg <= 1'b1;
              state_reg <= ST_PICK;
            end else begin
              // ladder sends the 100% code when no scaling is wanted
              div_num_reg <= {8'h0, 24'(wdata_reg[16:0]) * 24'(pct)};
              div_den_reg <= {25'h0, PCT_FULL};
              div_start_reg <= 1'b1;
              busy_reg <= 1'b1;
              state_reg <= ST_SCALE;
            end
          end
        end
        ST_SCALE: begin
          if (div_done) begin
            eff_reg <= div_q[16:0];
            state_reg <= ST_PICK;
          end
        end
        ST_PICK: begin
          gear_idx_reg <= pick_idx;
          div_num_reg <= {3'h0, 29'(eff_reg) * 29'(DAC_FULL)};
          div_den_reg <= {15'h0, gear_max_reg[pick_idx]};
          div_start_reg <= 1'b1;
          state_reg <= ST_CONV;
        end
        ST_CONV: begin
          if (div_done) begin
            // clamp instead of wrapping when over the gear's full scale
            plc_out_reg.analog_code <= (div_q > {20'h0, DAC_FULL}) ? DAC_FULL : div_q[11:0];
            if (plc_in.aux_function_lock) begin
              busy_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              plc_out_reg.gear_report <= 4'h1 << gear_idx_reg;
              plc_out_reg.speed_strobe <= 1'b1;
              state_reg <= ST_HANDSHAKE;
            end
          end
        end
        ST_HANDSHAKE: begin
          // the ladder raises completion only after all functions end
          if (plc_in.aux_done_input) begin
            plc_out_reg.speed_strobe <= 1'b0;
            plc_out_reg.speed_code <= 32'h0;
            busy_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // checks on the sequencer
  mode_select_a: assert property (ctrl_reg[CTRL_ANALOG] |-> plc_out_reg.speed_code == 32'h0)
    else $error("speed code driven in analog mode");
  code_range_a: assert property (cmd_go && !ctrl_reg[CTRL_ANALOG] && wdata_reg[16:0] > MAX_CODE
    |=> plc_out_reg.alarm && !plc_out_reg.speed_strobe && state_reg == ST_IDLE)
    else $error("out of range code not alarmed");
  code_onehot_a: assert property ($onehot0(plc_out_reg.speed_code))
    else $error("more than one speed code bit");
  strobe_code_a: assert property (cmd_go && !ctrl_reg[CTRL_ANALOG] && wdata_reg[16:0] <= MAX_CODE
    && !plc_in.aux_function_lock |=> plc_out_reg.speed_strobe
    && plc_out_reg.speed_code[cmd_reg[2:0]])
    else $error("strobe or code bit missing");
  thread_bypass_a: assert property (state_reg == ST_PICK && ctrl_reg[CTRL_THREAD] && ctrl_reg[CTRL_ANALOG]
    && $past(state_reg) == ST_IDLE |-> eff_reg == cmd_reg)
    else $error("override applied while threading");
  override_span_a: assert property (pct >= OVR_BASE && pct <= 7'h78)
    else $error("override outside 50 to 120 percent");
  gear_count_a: assert property (!ctrl_reg[CTRL_FOUR] && !ctrl_reg[CTRL_TTYPE] && state_reg == ST_PICK
    |=> gear_idx_reg <= 2'h1)
    else $error("upper gear picked with two gears");
  gear_report_a: assert property ($onehot0(plc_out_reg.gear_report))
    else $error("gear report not one hot");
  hold_strobe_a: assert property (state_reg == ST_HANDSHAKE && !plc_in.aux_done_input
    |=> plc_out_reg.speed_strobe && busy_reg)
    else $error("strobe dropped before completion");
  busy_release_a: assert property ($fell(busy_reg) |-> $past(plc_in.aux_done_input)
    || $past(plc_in.aux_function_lock) || !$past(reset_n))
    else $error("block advanced without completion");
  lock_strobe_a: assert property ($rose(plc_out_reg.speed_strobe) |-> !$past(plc_in.aux_function_lock))
    else $error("strobe raised under function lock");
  ttype_gear_a: assert property (state_reg == ST_PICK && ctrl_reg[CTRL_TTYPE] && plc_in.gear_in == 4'h4
    |=> gear_idx_reg == 2'h2)
    else $error("ladder gear not followed");
  gear_strobe_a: assert property ($changed(plc_out_reg.gear_report) && $past(reset_n)
    |-> plc_out_reg.speed_strobe)
    else $error("gear change without strobe");
endmodule
`default_nettype wire

// ===== tb/ssg_ladder_model.sv
// ssg_ladder_model: machine-side ladder program answering the speed strobe
// assumes strobe and completion are levels sampled on clk_sys
`timescale 1ns/1ps
`default_nettype none
module ssg_ladder_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // device side
  input wire logic speed_strobe,
  input wire logic slow,
  output logic aux_done_input
);
  logic [3:0] wait_reg; // cycles since the strobe was seen

  // completion only after the function has run, and low again once the strobe drops,
  // so a stale high never finishes the next command at once
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wait_reg <= 4'h0;
      aux_done_input <= 1'b0;
    end else if (!speed_strobe) begin
      wait_reg <= 4'h0;
      aux_done_input <= 1'b0;
    end else if (wait_reg == (slow ? 4'hc : 4'h1)) begin
      aux_done_input <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/test_spindle_speed_gear_control.sv
// test_spindle_speed_gear_control: row-driven bench for the spindle speed block
// assumes the ladder model beside it and bready/rready held high throughout
`timescale 1ns/1ps
`default_nettype none
module test_spindle_speed_gear_control;
  import ssg_pkg::*;
  // one analog case: inputs, then expected outputs
  typedef struct packed {
    logic [3:0] ctrl;
    logic [2:0] ovr;
    logic [3:0] gin;
    logic [16:0] cmd;
    logic [11:0] code;
    logic [3:0] gear;
  } ssg_row_s;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b1;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b1;
  ssg_plc_in_s plc_in;
  ssg_plc_out_s plc_out_reg;
  logic busy_reg;
  logic [7:0] ovr = 8'h05; // 100% unless a case asks for scaling
  logic [3:0] gin = 4'h0;
  logic lock = 1'b0;
  logic slow = 1'b0;
  logic done_w;
  int num_errors = 0;
  int checks_done = 0;
  ssg_row_s rows [9];
  logic [31:0] rd;
  logic [1:0] rsp;

  // the period is 25 ns
  always #12.5 clk_sys = ~clk_sys;
  always_comb plc_in = {ovr, gin, done_w, lock};

  ssg_spindle_speed u_ssg_spindle_speed (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .plc_in, .plc_out_reg, .busy_reg);
  ssg_ladder_model u_ssg_ladder_model (.clk_sys, .reset_n, .speed_strobe(plc_out_reg.speed_strobe), .slow,
    .aux_done_input(done_w));

  // compare with case equality so an unknown never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    r = s_axi_bresp;
    if (n >= 200) chk(32'h0, 32'h1);
  endtask

  // read: data taken at the edge where rvalid is sampled
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 200) chk(32'h0, 32'h1);
  endtask

  // bounded wait for the strobe to reach a level; analog work takes about 70 edges
  task automatic wait_strobe(input logic want);
    int n;
    n = 0;
    while (plc_out_reg.speed_strobe !== want && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 400) chk(32'h0, 32'h1);
  endtask

  task automatic end_test(input string name);
    $display("test %s finished, errors so far %0d", name, num_errors);
  endtask

  task automatic close_out;
    $display("checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog: the whole run needs about a thousand cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end

  initial begin
    // gear 1 at 3000, gear 2 at 6000, gear 4 at 12000
    rows = '{'{4'h1, 3'h5, 4'h0, 17'h005dc, 12'h7ff, 4'h1}, '{4'h1, 3'h0, 4'h0, 17'h005dc, 12'h3ff, 4'h1},
      '{4'h1, 3'h7, 4'h0, 17'h00bb8, 12'h999, 4'h2}, '{4'h9, 3'h0, 4'h0, 17'h005dc, 12'h7ff, 4'h1},
      '{4'h3, 3'h5, 4'h0, 17'h02328, 12'hbff, 4'h8}, '{4'h3, 3'h5, 4'h0, 17'h04e20, 12'hfff, 4'h8},
      '{4'h5, 3'h5, 4'h2, 17'h005dc, 12'h3ff, 4'h2}, '{4'h5, 3'h5, 4'h1, 17'h005dc, 12'h7ff, 4'h1},
      '{4'h7, 3'h5, 4'h4, 17'h005dc, 12'h7ff, 4'h4}};
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    // ordinary analog cases, one row each
    axw(ADDR_GMAX0 + 8'h04, 32'h00001770, rsp);
    axw(ADDR_GMAX3, 32'h00002ee0, rsp);
    foreach (rows[i]) begin
      axw(ADDR_CTRL, {28'h0, rows[i].ctrl}, rsp);
      ovr <= {5'h00, rows[i].ovr};
      gin <= rows[i].gin;
      slow <= i[0];
      axw(ADDR_CMD, {15'h0, rows[i].cmd}, rsp);
      wait_strobe(1'b1);
      chk(plc_out_reg.analog_code, rows[i].code);
      chk(plc_out_reg.gear_report, rows[i].gear);
      chk(busy_reg, 1'b1);
      wait_strobe(1'b0);
      chk(busy_reg, 1'b0);
      end_test("analog row");
    end
    // reset values and a read-back, after a second reset
    reset_n <= 1'b0;
    @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    axr(ADDR_CTRL, rd, rsp);
    chk(rd, 32'h0);
    axr(ADDR_GMAX0, rd, rsp);
    chk(rd, {15'h0, GEAR_MAX_RST});
    axr(ADDR_STATUS, rd, rsp);
    chk(rd, 32'h0);
    end_test("reset");
    // every gear-mode code, fast and slow ladder
    ovr <= 8'h05;
    for (int c = 0; c < 8; c++) begin
      slow <= c[0];
      axw(ADDR_CMD, c, rsp);
      wait_strobe(1'b1);
      chk(plc_out_reg.speed_code, 32'h1 << c);
      chk(busy_reg, 1'b1);
      chk(done_w, 1'b0);
      wait_strobe(1'b0);
      chk(plc_out_reg.speed_code, 32'h0);
    end
    end_test("gear codes");
    // out-of-range code raises the alarm, which clears on write
    axw(ADDR_CMD, 32'h8, rsp);
    repeat (4) @(posedge clk_sys);
    chk(plc_out_reg.alarm, 1'b1);
    chk(plc_out_reg.speed_strobe, 1'b0);
    axr(ADDR_ALARM, rd, rsp);
    chk(rd[0], 1'b1);
    axw(ADDR_ALARM, 32'h1, rsp);
    axr(ADDR_ALARM, rd, rsp);
    chk(rd[0], 1'b0);
    end_test("alarm");
    // refused register accesses
    axw(ADDR_STATUS, 32'h1, rsp);
    chk(rsp, RESP_SLVERR);
    axr(8'h24, rd, rsp);
    chk(rsp, RESP_SLVERR);
    chk(rd, 32'h0);
    end_test("refused");
    // function lock: gear mode silent, analog output still moves
    lock <= 1'b1;
    axw(ADDR_CMD, 32'h3, rsp);
    repeat (20) @(posedge clk_sys);
    chk(plc_out_reg.speed_strobe, 1'b0);
    chk(plc_out_reg.speed_code, 32'h0);
    axw(ADDR_CTRL, 32'h1, rsp);
    axw(ADDR_CMD, 32'h00000bb8, rsp);
    repeat (150) @(posedge clk_sys);
    chk(plc_out_reg.analog_code, DAC_FULL);
    chk(plc_out_reg.speed_strobe, 1'b0);
    end_test("lock");
    close_out();
  end
endmodule
`default_nettype wire
